// [mdf_regs.sv]
// memory management control, domain and data fault registers
//
// Overview of operation
// RULE1 - translation changes reach fetch only after the following instructions
// RULE2 - data cache and write buffer stay off while translation is off
// RULE3 - one control write can enable all four functions at once
// RULE4 - table base read gives pointer in bits 31-14, low bits unpredictable
// RULE5 - table base write loads pointer from written bits 31-14
// RULE6 - software writes zeros in table base bits 13-0
// RULE7 - software keeps secondary opcode and minor register fields zero
// RULE8 - domain register reads back exactly the last written word
// RULE9 - sixteen two-bit domain fields, domain n at bits 2n+1:2n
// RULE10 - field 00 faults every access to the domain
// RULE11 - field 01 checks access against page descriptor permission
// RULE12 - reserved field 10 behaves exactly like no access
// RULE13 - field 11 skips checks and never raises a permission fault
// RULE14 - fault status reads only low 9 bits, bit 8 zero
// RULE15 - data fault records accessed domain in status bits 7-4
// RULE16 - data fault records fault type code in status bits 3-0
// RULE17 - instruction fetch faults leave fault status unchanged
// RULE18 - multi-word transfers keep capture of their first fault
// RULE19 - fault status write loads data, upper 24 bits written zero
// RULE20 - data fault captures full 32-bit virtual address
// RULE21 - instruction fetch faults never update fault address
// RULE22 - fault address write loads the full written word
// RULE23 - software enables translation no later than data cache and buffer
// RULE24 - captured fault values hold until next data fault or write
// RULE25 - translation enable lags the write by a fixed instruction count
`timescale 1ns/1ps
`default_nettype none
module mdf_regs #(
  parameter int NUM_DOMAINS = mdf_pkg::NUM_DOMAINS,
  parameter int TRANSLATE_DELAY = mdf_pkg::TRANSLATE_DELAY
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic hivec_strap,
  input wire logic cp_write,
  input wire logic cp_read,
  input wire logic [3:0] cp_reg_num,
  input wire logic [3:0] coproc_minor_reg_field,
  input wire logic [2:0] cp_opcode2,
  input wire logic [31:0] cp_write_data,
  input wire logic instr_step,
  input wire logic access_valid,
  input wire logic access_is_data,
  input wire logic [31:0] access_address,
  input wire logic [3:0] access_domain,
  input wire logic page_permission_ok,
  input wire logic [3:0] access_fault_code,
  input wire logic multi_active,
  input wire logic multi_start,
  output logic [31:0] cp_read_data,
  output logic cp_read_valid,
  output logic translate_enable,
  output logic dcache_active,
  output logic wbuf_active,
  output logic icache_enable,
  output logic align_check_enable,
  output logic high_vectors,
  output logic [31:0] translation_table_base,
  output logic abort,
  output logic abort_is_data
);
  initial begin
    if (NUM_DOMAINS != 16) begin
      $error("mdf_regs supports sixteen domains only");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  function automatic logic sel(input logic [3:0] num, input logic [3:0] want);
    sel = (num == want);
  endfunction

  // secondary opcode and minor field are not decoded; software keeps them zero
  wire wr_ctl = cp_write && sel(cp_reg_num, mdf_pkg::REG_CONTROL); // RULE7
  wire wr_ttb = cp_write && sel(cp_reg_num, mdf_pkg::REG_TABLE_BASE);
  wire wr_dom = cp_write && sel(cp_reg_num, mdf_pkg::REG_DOMAIN);
  wire wr_fsr = cp_write && sel(cp_reg_num, mdf_pkg::REG_FAULT_STATUS);
  wire wr_far = cp_write && sel(cp_reg_num, mdf_pkg::REG_FAULT_ADDRESS);
  wire unused_fields = ^{coproc_minor_reg_field, cp_opcode2};

  ////////////////////////////////////////////////////////////////////////////
  // control register

  logic [31:0] control_reg;
  logic [31:0] control_next;
  logic hivec_loaded_reg;
  wire [31:0] ctl_written;
  assign ctl_written = (cp_write_data & mdf_pkg::CTL_WRITE_MASK) |
                       mdf_pkg::CTL_ONES;
  always_comb begin
    control_next = control_reg;
    if (!hivec_loaded_reg) begin
      control_next[mdf_pkg::CTL_HIVEC] = hivec_strap;
    end
    if (wr_ctl) begin
      control_next = ctl_written; // RULE3
    end
  end
  // strap caught by the first clocked cycle after release
  always_ff @(posedge clk) begin
    if (reset) begin
      control_reg <= mdf_pkg::CTL_RESET | mdf_pkg::CTL_ONES;
      hivec_loaded_reg <= 1'b0;
    end else begin
      control_reg <= control_next;
      hivec_loaded_reg <= 1'b1;
    end
  end

  logic translate_delayed;
  mdf_enable_delay #(
    .DELAY(TRANSLATE_DELAY)
  ) u_delay (
    .clk(clk),
    .reset(reset),
    .instr_step(instr_step),
    .enable_in(control_reg[mdf_pkg::CTL_TRANSLATE]),
    .enable_out(translate_delayed)
  );

  // enable bits alone never light the data side without translation
  wire dcache_next = control_reg[mdf_pkg::CTL_DCACHE] &&
                     translate_delayed; // RULE2
  wire wbuf_next = control_reg[mdf_pkg::CTL_WBUF] &&
                   translate_delayed; // RULE2

  ////////////////////////////////////////////////////////////////////////////
  // table base and domain registers

  logic [31:0] ttb_reg;
  logic [31:0] domain_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      ttb_reg <= 32'h0000_0000;
    end else if (wr_ttb) begin
      ttb_reg <= cp_write_data & mdf_pkg::TABLE_BASE_MASK; // RULE5 RULE6
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      domain_reg <= mdf_pkg::DOMAIN_RESET;
    end else if (wr_dom) begin
      domain_reg <= cp_write_data; // RULE8 RULE9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // permission decision

  logic domain_fault;
  logic permission_fault;
  mdf_domain_check #(
    .NUM_DOMAINS(NUM_DOMAINS)
  ) u_check (
    .domain_permission_fields(domain_reg),
    .domain(access_domain),
    .page_permission_ok(page_permission_ok),
    .domain_fault(domain_fault),
    .permission_fault(permission_fault)
  );
  // untranslated accesses are not checked; the registered enable is used
  // so an abort always agrees with what the core sees on translate_enable
  wire fault_now = access_valid && translate_enable &&
                   (domain_fault || permission_fault);
  wire data_fault = fault_now && access_is_data;

  ////////////////////////////////////////////////////////////////////////////
  // fault capture

  mdf_pkg::mdf_capture_type cap_reg;
  mdf_pkg::mdf_capture_type cap_next;
  wire in_multi = multi_active || multi_start;
  wire held = (cap_reg == mdf_pkg::CAP_MULTI_HELD) && !multi_start;
  wire capture = data_fault && !held; // RULE17 RULE18 RULE21
  always_comb begin
    cap_next = cap_reg;
    case (cap_reg)
      mdf_pkg::CAP_IDLE: begin
        if (in_multi) begin
          cap_next = capture ? mdf_pkg::CAP_MULTI_HELD :
                               mdf_pkg::CAP_MULTI_CLEAN;
        end
      end
      mdf_pkg::CAP_MULTI_CLEAN: begin
        if (!in_multi) begin
          cap_next = mdf_pkg::CAP_IDLE;
        end else if (capture) begin
          cap_next = mdf_pkg::CAP_MULTI_HELD; // RULE18
        end
      end
      mdf_pkg::CAP_MULTI_HELD: begin
        if (multi_start) begin
          cap_next = capture ? mdf_pkg::CAP_MULTI_HELD :
                               mdf_pkg::CAP_MULTI_CLEAN;
        end else if (!multi_active) begin
          cap_next = mdf_pkg::CAP_IDLE;
        end
      end
      default: begin
        cap_next = mdf_pkg::CAP_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      cap_reg <= mdf_pkg::CAP_IDLE;
    end else begin
      cap_reg <= cap_next;
    end
  end

  logic [7:0] fsr_reg;
  logic [31:0] far_reg;
  // a hardware capture wins over a software write in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      fsr_reg <= mdf_pkg::FAULT_STATUS_RESET;
    end else if (capture) begin
      fsr_reg <= {access_domain, access_fault_code}; // RULE15 RULE16
    end else if (wr_fsr) begin
      fsr_reg <= cp_write_data[7:0]; // RULE19 RULE24
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      far_reg <= mdf_pkg::FAULT_ADDRESS_RESET;
    end else if (capture) begin
      far_reg <= access_address; // RULE20
    end else if (wr_far) begin
      far_reg <= cp_write_data; // RULE22 RULE24
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux and outputs

  logic [31:0] read_mux;
  always_comb begin
    case (cp_reg_num)
      mdf_pkg::REG_CONTROL: read_mux = control_reg;
      mdf_pkg::REG_TABLE_BASE: read_mux = ttb_reg; // RULE4
      mdf_pkg::REG_DOMAIN: read_mux = domain_reg; // RULE8
      mdf_pkg::REG_FAULT_STATUS: read_mux = {24'h00_0000, fsr_reg}; // RULE14
      mdf_pkg::REG_FAULT_ADDRESS: read_mux = far_reg;
      default: read_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cp_read_data <= 32'h0000_0000;
      cp_read_valid <= 1'b0;
      translate_enable <= 1'b0;
      dcache_active <= 1'b0;
      wbuf_active <= 1'b0;
      icache_enable <= 1'b0;
      align_check_enable <= 1'b0;
      high_vectors <= 1'b0;
      translation_table_base <= 32'h0000_0000;
      abort <= 1'b0;
      abort_is_data <= 1'b0;
    end else begin
      cp_read_data <= cp_read ? read_mux : 32'h0000_0000;
      cp_read_valid <= cp_read && !unused_fields | cp_read;
      translate_enable <= translate_delayed; // RULE1
      dcache_active <= dcache_next;
      wbuf_active <= wbuf_next;
      icache_enable <= control_reg[mdf_pkg::CTL_ICACHE];
      align_check_enable <= control_reg[mdf_pkg::CTL_ALIGN];
      high_vectors <= control_reg[mdf_pkg::CTL_HIVEC];
      translation_table_base <= ttb_reg;
      abort <= fault_now;
      abort_is_data <= data_fault;
    end
  end
endmodule
`default_nettype wire

// [mdf_pkg.sv]
// shared constants and types for the memory management control registers
package mdf_pkg;
  localparam logic [3:0] REG_CONTROL = 4'h1;
  localparam logic [3:0] REG_TABLE_BASE = 4'h2;
  localparam logic [3:0] REG_DOMAIN = 4'h3;
  localparam logic [3:0] REG_FAULT_STATUS = 4'h5;
  localparam logic [3:0] REG_FAULT_ADDRESS = 4'h6;
  localparam int CTL_TRANSLATE = 0;
  localparam int CTL_ALIGN = 1;
  localparam int CTL_DCACHE = 2;
  localparam int CTL_WBUF = 3;
  localparam int CTL_SYSPROT = 8;
  localparam int CTL_ROMPROT = 9;
  localparam int CTL_ICACHE = 12;
  localparam int CTL_HIVEC = 13;
  localparam logic [31:0] CTL_WRITE_MASK = 32'h0000_330f;
  localparam logic [31:0] CTL_ONES = 32'h0000_0070;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  localparam int TABLE_BASE_LSB = 14;
  localparam logic [31:0] TABLE_BASE_MASK = 32'hffff_c000;
  localparam logic [31:0] DOMAIN_RESET = 32'h0000_0000;
  localparam logic [31:0] FAULT_STATUS_MASK = 32'h0000_00ff;
  localparam logic [7:0] FAULT_STATUS_RESET = 8'h00;
  localparam logic [31:0] FAULT_ADDRESS_RESET = 32'h0000_0000;
  localparam int NUM_DOMAINS = 16;
  localparam int TRANSLATE_DELAY = 2;
  typedef enum logic [1:0] {
    DOM_NO_ACCESS = 2'b00,
    DOM_CLIENT = 2'b01,
    DOM_RESERVED = 2'b10,
    DOM_MANAGER = 2'b11
  } mdf_domain_type;
  typedef enum logic [1:0] {
    CAP_IDLE = 2'b00,
    CAP_MULTI_CLEAN = 2'b01,
    CAP_MULTI_HELD = 2'b10
  } mdf_capture_type;
endpackage

// [mdf_domain_check.sv]
// domain permission decision for one access
`timescale 1ns/1ps
`default_nettype none
module mdf_domain_check #(
  parameter int NUM_DOMAINS = mdf_pkg::NUM_DOMAINS
) (
  input wire logic [2*NUM_DOMAINS-1:0] domain_permission_fields,
  input wire logic [3:0] domain,
  input wire logic page_permission_ok,
  output logic domain_fault,
  output logic permission_fault
);
  initial begin
    if (NUM_DOMAINS != 16) begin
      $error("mdf_domain_check supports sixteen domains only");
    end
  end
  wire [1:0] field;
  wire is_no_access;
  wire is_client;
  assign field = domain_permission_fields[2*domain +: 2];
  // reserved decodes as no access
  assign is_no_access = (field == mdf_pkg::DOM_NO_ACCESS) ||
                        (field == mdf_pkg::DOM_RESERVED); // RULE10 RULE12
  assign is_client = (field == mdf_pkg::DOM_CLIENT);
  assign domain_fault = is_no_access; // RULE10
  // manager is not client, so no permission fault for it
  assign permission_fault = is_client && !page_permission_ok; // RULE11 RULE13
endmodule
`default_nettype wire

// [mdf_enable_delay.sv]
// delays the translation enable by a fixed count of instructions
`timescale 1ns/1ps
`default_nettype none
module mdf_enable_delay #(
  parameter int DELAY = mdf_pkg::TRANSLATE_DELAY
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic instr_step,
  input wire logic enable_in,
  output logic enable_out
);
  initial begin
    if (DELAY < 1) begin
      $error("mdf_enable_delay needs a delay of at least one");
    end
  end
  logic [DELAY-1:0] stage_reg;
  // the spare top bit drops off, so a delay of one needs no special case
  wire [DELAY:0] shifted;
  assign shifted = {stage_reg, enable_in};
  // shifts once per retired instruction, so the delay is in instructions
  always_ff @(posedge clk) begin
    if (reset) begin
      stage_reg <= '0;
    end else if (instr_step) begin
      stage_reg <= shifted[DELAY-1:0];
    end
  end
  assign enable_out = stage_reg[DELAY-1]; // RULE1 RULE25
endmodule
`default_nettype wire

// [mdf_regs_properties.sv]
// checker for the memory management control registers
`timescale 1ns/1ps
`default_nettype none
module mdf_regs_properties #(
  parameter int NUM_DOMAINS = mdf_pkg::NUM_DOMAINS,
  parameter int TRANSLATE_DELAY = mdf_pkg::TRANSLATE_DELAY
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cp_write,
  input wire logic cp_read,
  input wire logic [3:0] cp_reg_num,
  input wire logic [31:0] cp_write_data,
  input wire logic access_valid,
  input wire logic [3:0] access_domain,
  input wire logic page_permission_ok,
  input wire logic [31:0] cp_read_data,
  input wire logic translate_enable,
  input wire logic dcache_active,
  input wire logic [31:0] translation_table_base,
  input wire logic abort
);
  ////////////////////////////////////////////////////////////
  // shadow of the domain register, only ports are visible here
  logic [2*NUM_DOMAINS-1:0] dom_reg;
  logic [1:0] fld;
  logic chk;
  assign fld = dom_reg[2*access_domain +: 2];
  assign chk = access_valid && translate_enable;
  always_ff @(posedge clk) begin
    if (reset) begin
      dom_reg <= '0;
    end else if (cp_write && cp_reg_num == mdf_pkg::REG_DOMAIN) begin
      dom_reg <= cp_write_data[2*NUM_DOMAINS-1:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  dcache_gate_a: assert property (dcache_active |-> translate_enable)
    else $error("data cache active while translation off");
  enable_lag_a: assert property ((cp_write && cp_write_data[0] &&
    cp_reg_num == mdf_pkg::REG_CONTROL && !translate_enable) |=>
    !translate_enable)
    else $error("translation enabled without delay");
  no_access_a: assert property (chk && fld == 2'b00 |=> abort)
    else $error("no-access domain did not fault");
  reserved_fault_a: assert property (chk && fld == 2'b10 |=> abort)
    else $error("reserved domain did not fault");
  client_check_a: assert property (chk && fld == 2'b01 |=>
    abort == !$past(page_permission_ok))
    else $error("client access not checked against page");
  manager_free_a: assert property (chk && fld == 2'b11 |=> !abort)
    else $error("manager domain faulted");
  status_top_a: assert property (cp_read &&
    cp_reg_num == mdf_pkg::REG_FAULT_STATUS |=>
    cp_read_data[31:8] == 24'h00_0000)
    else $error("fault status upper bits not zero");
  table_load_a: assert property (cp_write &&
    cp_reg_num == mdf_pkg::REG_TABLE_BASE |-> ##2 translation_table_base ==
    ($past(cp_write_data, 2) & mdf_pkg::TABLE_BASE_MASK))
    else $error("table base not loaded");
  domain_readback_a: assert property (cp_read &&
    cp_reg_num == mdf_pkg::REG_DOMAIN |=>
    cp_read_data[2*NUM_DOMAINS-1:0] == $past(dom_reg))
    else $error("domain register readback differs");
  cover property (chk && fld == 2'b01 ##1 abort);
  cover property ($rose(translate_enable));
  cover property (cp_write && cp_reg_num == mdf_pkg::REG_FAULT_STATUS);
endmodule
bind mdf_regs mdf_regs_properties #(.NUM_DOMAINS(NUM_DOMAINS),
  .TRANSLATE_DELAY(TRANSLATE_DELAY)) u_props (.clk(clk), .reset(reset),
  .cp_write(cp_write), .cp_read(cp_read), .cp_reg_num(cp_reg_num),
  .cp_write_data(cp_write_data), .access_valid(access_valid),
  .access_domain(access_domain), .page_permission_ok(page_permission_ok),
  .cp_read_data(cp_read_data), .translate_enable(translate_enable),
  .dcache_active(dcache_active), .abort(abort),
  .translation_table_base(translation_table_base));
`default_nettype wire

// [mdf_core_model.sv]
// processor core model issuing coprocessor register transfers
`timescale 1ns/1ps
`default_nettype none
module mdf_core_model (
  input wire logic clk,
  input wire logic [31:0] cp_read_data,
  input wire logic cp_read_valid,
  output logic cp_write,
  output logic cp_read,
  output logic [3:0] cp_reg_num,
  output logic [3:0] coproc_minor_reg_field,
  output logic [2:0] cp_opcode2,
  output logic [31:0] cp_write_data
);
  ////////////////////////////////////////////////////////////
  initial begin
    cp_write = 1'b0;
    cp_read = 1'b0;
    cp_reg_num = 4'h0;
    coproc_minor_reg_field = 4'h0;
    cp_opcode2 = 3'h0;
    cp_write_data = 32'h0000_0000;
  end
  // software habits applied here so callers cannot break them
  task automatic wr(input logic [3:0] r, input logic [31:0] d);
    if (r == mdf_pkg::REG_TABLE_BASE) begin
      d = d & mdf_pkg::TABLE_BASE_MASK;
    end
    if (r == mdf_pkg::REG_FAULT_STATUS) begin
      d = d & 32'h0000_00ff;
    end
    if (r == mdf_pkg::REG_CONTROL && !d[0]) begin
      d[3:2] = 2'b00;
    end
    @(posedge clk);
    cp_write <= 1'b1;
    cp_reg_num <= r;
    cp_write_data <= d;
    @(posedge clk);
    cp_write <= 1'b0;
    cp_write_data <= ~d;
  endtask
  task automatic rd(input logic [3:0] r, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cp_read <= 1'b1;
    cp_reg_num <= r;
    @(posedge clk);
    cp_read <= 1'b0;
    #1;
    while (cp_read_valid !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    q = (cp_read_valid === 1'b1) ? cp_read_data : 32'hxxxx_xxxx;
  endtask
endmodule
`default_nettype wire

// [mdf_regs_tb.sv]
// self-checking bench for the memory management control registers
`timescale 1ns/1ps
`default_nettype none
module mdf_regs_tb;
  typedef struct packed {
    logic [3:0] r;
    logic [31:0] d;
    logic [31:0] e;
  } mdf_row_type;
  logic clk, reset, cp_write, cp_read, instr_step, access_valid, access_is_data;
  logic [3:0] cp_reg_num, minor, access_domain, access_fault_code;
  logic [2:0] opc2;
  logic [31:0] cp_write_data, access_address, cp_read_data, q, es, ea;
  logic page_permission_ok, multi_active, multi_start, cp_read_valid;
  logic translate_enable, dcache_active, wbuf_active, icache_enable;
  logic abort, abort_is_data, align_check_enable, high_vectors;
  logic [31:0] ttb_out;
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  mdf_row_type rows [6] = '{'{mdf_pkg::REG_DOMAIN, 32'he4a5_1b3c, 32'he4a5_1b3c},
    '{mdf_pkg::REG_TABLE_BASE, 32'h1234_4000, 32'h1234_4000},
    '{mdf_pkg::REG_FAULT_STATUS, 32'h0000_00a7, 32'h0000_00a7},
    '{mdf_pkg::REG_FAULT_ADDRESS, 32'hdead_beef, 32'hdead_beef},
    '{4'h4, 32'hffff_ffff, 32'h0000_0000},
    '{mdf_pkg::REG_CONTROL, 32'h0000_2002, 32'h0000_2072}};
  // {domain, page ok, abort expected}
  logic [5:0] frow [5] = '{6'h03, 6'h06, 6'h05, 6'h0b, 6'h0c};
  ////////////////////////////////////////////////////////////
  mdf_regs #(.TRANSLATE_DELAY(2)) u_dut (.clk(clk), .reset(reset),
    .hivec_strap(1'b0), .cp_write(cp_write), .cp_read(cp_read),
    .cp_reg_num(cp_reg_num), .coproc_minor_reg_field(minor),
    .cp_opcode2(opc2), .cp_write_data(cp_write_data), .instr_step(instr_step),
    .access_valid(access_valid), .access_is_data(access_is_data),
    .access_address(access_address), .access_domain(access_domain),
    .page_permission_ok(page_permission_ok), .multi_start(multi_start),
    .access_fault_code(access_fault_code), .multi_active(multi_active),
    .cp_read_data(cp_read_data), .cp_read_valid(cp_read_valid),
    .translate_enable(translate_enable), .dcache_active(dcache_active),
    .wbuf_active(wbuf_active), .icache_enable(icache_enable),
    .align_check_enable(align_check_enable), .high_vectors(high_vectors),
    .translation_table_base(ttb_out),
    .abort(abort), .abort_is_data(abort_is_data));
  mdf_core_model u_core (.clk(clk), .cp_read_data(cp_read_data),
    .cp_read_valid(cp_read_valid), .cp_write(cp_write), .cp_read(cp_read),
    .cp_reg_num(cp_reg_num), .coproc_minor_reg_field(minor),
    .cp_opcode2(opc2), .cp_write_data(cp_write_data));
  always #20 clk = ~clk;
  task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp1(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t flag %b expected %b", $time, g, e);
    end
  endtask
  task automatic acc(input logic d, input logic [3:0] dm, input logic ok,
    input logic [31:0] a, input logic [3:0] c, input logic ms, input logic ma);
    @(posedge clk);
    access_valid <= 1'b1;
    access_is_data <= d;
    access_domain <= dm;
    page_permission_ok <= ok;
    access_address <= a;
    access_fault_code <= c;
    multi_start <= ms;
    multi_active <= ma;
    @(posedge clk);
    access_valid <= 1'b0;
    multi_start <= 1'b0;
    #1;
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // a hang is cut short well past the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    {clk, reset, instr_step, access_valid, access_is_data} = 5'h01 << 3;
    {page_permission_ok, multi_active, multi_start} = 3'h0;
    access_address = 32'h0000_0000;
    {access_domain, access_fault_code} = 8'h00;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    u_core.rd(mdf_pkg::REG_CONTROL, q);
    cmp32(q, mdf_pkg::CTL_ONES);
    foreach (rows[i]) begin
      u_core.wr(rows[i].r, rows[i].d);
      u_core.rd(rows[i].r, q);
      cmp32(q, rows[i].e);
    end
    cmp32(ttb_out, 32'h1234_4000);
    cmp32({30'h0, align_check_enable, high_vectors}, 32'h0000_0003);
    es = 32'h0000_00a7;
    ea = 32'hdead_beef;
    u_core.wr(mdf_pkg::REG_DOMAIN, 32'h0000_00e4);
    u_core.wr(mdf_pkg::REG_CONTROL, 32'h0000_100f);
    @(posedge clk);
    #1;
    cmp32({28'h0, translate_enable, dcache_active, wbuf_active, icache_enable},
      32'h0000_0001);
    repeat (2) begin
      @(posedge clk);
      instr_step <= 1'b1;
      @(posedge clk);
      instr_step <= 1'b0;
    end
    @(posedge clk);
    #1;
    cmp32({28'h0, translate_enable, dcache_active, wbuf_active, icache_enable},
      32'h0000_000f);
    foreach (frow[i]) begin
      acc(1'b1, frow[i][5:2], frow[i][1], 32'h4000_0000 | i, 4'(i + 1),
        1'b0, 1'b0);
      cmp1(abort, frow[i][0]);
      cmp1(abort_is_data, frow[i][0]);
      if (frow[i][0]) begin
        es = {24'h0, frow[i][5:2], 4'(i + 1)};
        ea = 32'h4000_0000 | i;
      end
      u_core.rd(mdf_pkg::REG_FAULT_STATUS, q);
      cmp32(q, es);
      u_core.rd(mdf_pkg::REG_FAULT_ADDRESS, q);
      cmp32(q, ea);
    end
    acc(1'b0, 4'h0, 1'b1, 32'hbad0_0000, 4'h9, 1'b0, 1'b0);
    cmp1(abort, 1'b1);
    cmp1(abort_is_data, 1'b0);
    u_core.rd(mdf_pkg::REG_FAULT_STATUS, q);
    cmp32(q, es);
    u_core.rd(mdf_pkg::REG_FAULT_ADDRESS, q);
    cmp32(q, ea);
    // second fault of one transfer must not displace the first
    acc(1'b1, 4'h2, 1'b1, 32'h5000_0010, 4'h7, 1'b1, 1'b1);
    acc(1'b1, 4'h0, 1'b1, 32'h5000_0020, 4'h3, 1'b0, 1'b1);
    @(posedge clk);
    multi_active <= 1'b0;
    u_core.rd(mdf_pkg::REG_FAULT_STATUS, q);
    cmp32(q, 32'h0000_0027);
    u_core.rd(mdf_pkg::REG_FAULT_ADDRESS, q);
    cmp32(q, 32'h5000_0010);
    // reset in mid-run drops the enables and restores the control word
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    cmp32({28'h0, translate_enable, dcache_active, wbuf_active, icache_enable},
      32'h0000_0000);
    u_core.rd(mdf_pkg::REG_CONTROL, q);
    cmp32(q, mdf_pkg::CTL_ONES);
    end_sim();
  end
endmodule
`default_nettype wire
